// [common/sdgc_defines.svh]
// Offsets, field positions, reset values and timing counts for the
// global configuration bank. Assumes a 50 MHz core clock.
`ifndef SDGC_DEFINES_SVH
`define SDGC_DEFINES_SVH
// Command addresses on the serial link
`define SDGC_ADDR_CONFIG 7'h01
`define SDGC_ADDR_SW_STATUS 7'h1f
`define SDGC_ADDR_FAULT 7'h21
// Configuration field positions
`define SDGC_POLL_BIT 13
`define SDGC_OVDIS_BIT 12
`define SDGC_WAKECHK_BIT 11
`define SDGC_INTSTYLE_BIT 10
// Reset value and writable bits of the configuration word
`define SDGC_CFG_RESET 24'h0008ff
`define SDGC_CFG_WMASK 24'h003cff
// Response word field positions
`define SDGC_RSP_FS_BIT 23
`define SDGC_RSP_INT_BIT 22
`define SDGC_RSP_SW_LSB 14
`define SDGC_FAULT_OV_BIT 6
// Times in ns and the core clock period
`define SDGC_CLK_NS 20
`define SDGC_POLL_LONG_NS 1000000
`define SDGC_POLL_SHORT_NS 55000
`define SDGC_INT_PULSE_NS 1000
`define SDGC_POLL_SHORT_CYC (`SDGC_POLL_SHORT_NS / `SDGC_CLK_NS)
`define SDGC_INT_PULSE_CYC (`SDGC_INT_PULSE_NS / `SDGC_CLK_NS)
`endif

// [common/sdgc_pkg.sv]
// Types shared by the link shifter and the configuration bank.
// Assumes a 32-bit serial frame: address, write flag, 24 data bits.
package sdgc_pkg;
  // One serial command frame, first bit on the wire at the top
  typedef struct packed {
    logic [6:0] addr;
    logic write;
    logic [23:0] data;
  } sdgc_cmd_type;

  // Power state of the device, one-hot
  typedef enum logic [1:0] {
    SDGC_NORMAL = 2'b01,
    SDGC_LOWPWR = 2'b10
  } sdgc_pwr_type;
endpackage

// [core/sdgc_link_shifter.sv]
// Serial link shifter running on the link's own clock.
// Assumes mode 0 framing: host samples and device samples on the rising edge.
`timescale 1ns/1ns
module sdgc_link_shifter
  import sdgc_pkg::*;
(
  input wire logic spiClk,
  input wire logic spiSelN,
  input wire logic spiMosi,
  input wire logic linkClear,
  input wire logic [31:0] respWord,
  output sdgc_cmd_type cmdWord,
  output logic cmdToggle,
  output logic spiMisoOut,
  output logic spiMisoOeN
);
  logic [5:0] bitCnt_reg; // Bits seen in this frame, saturates at 32
  logic [5:0] bitCnt_next;
  logic [31:0] shift_reg; // Incoming bits
  logic [31:0] shift_next;
  sdgc_cmd_type cmd_reg; // Last complete frame
  sdgc_cmd_type cmd_next;
  logic tgl_reg; // Flips once per complete frame
  logic tgl_next;

  // Counter and shifter next values
  always_comb begin
    bitCnt_next = bitCnt_reg;
    shift_next = {shift_reg[30:0], spiMosi};
    if (!bitCnt_reg[5]) begin
      bitCnt_next = bitCnt_reg + 6'h01;
    end
  end

  // Frame state; select high clears it without needing a link edge
  always_ff @(posedge spiClk or posedge spiSelN) begin
    if (spiSelN) begin
      bitCnt_reg <= 6'h00;
      shift_reg <= 32'h0000_0000;
    end else begin
      bitCnt_reg <= bitCnt_next;
      shift_reg <= shift_next;
    end
  end

  // Hand-off word; held stable until the next full frame
  always_comb begin
    cmd_next = cmd_reg;
    tgl_next = tgl_reg;
    if (bitCnt_reg == 6'h1f) begin
      cmd_next = {shift_reg[30:0], spiMosi};
      tgl_next = ~tgl_reg;
    end
  end

  // Cleared from the core reset, which is a core flop
  always_ff @(posedge spiClk or posedge linkClear) begin
    if (linkClear) begin
      cmd_reg <= '0;
      tgl_reg <= 1'b0;
    end else begin
      cmd_reg <= cmd_next;
      tgl_reg <= tgl_next;
    end
  end

  assign cmdWord = cmd_reg;
  assign cmdToggle = tgl_reg;
  // Response is steady for the whole frame, so a plain select suffices
  assign spiMisoOut = (!spiSelN && !bitCnt_reg[5]) ? respWord[5'(~bitCnt_reg[4:0])] : 1'b0;
  assign spiMisoOeN = spiSelN;
endmodule // sdgc_link_shifter

// [core/sdgc_config_bank.sv]
// Global configuration bank of the switch detection device.
// Assumes the host leaves at least 8 core cycles between frames.
`timescale 1ns/1ns
`include "sdgc_defines.svh"
module sdgc_config_bank
  import sdgc_pkg::*;
#(
  parameter int POLL_LONG_CYC = `SDGC_POLL_LONG_NS / `SDGC_CLK_NS
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic spiClk,
  input wire logic spiSelN,
  input wire logic spiMosi,
  output logic spiMisoOut,
  output logic spiMisoOeN,
  input wire logic batteryOvervoltage,
  input wire logic ioSupplyGood,
  input wire logic wakeInN,
  input wire logic [7:0] inputAboveThreshold,
  input wire logic lowPowerRequest,
  output logic overvoltageFlag,
  output logic wettingLimit2mA,
  output logic lowPowerState,
  output logic wakeEvent,
  output logic intOutN,
  output logic [7:0] inputTypeBattery,
  output logic sbPollActive,
  output logic sbPollDone
);
  localparam int PCW = 16; // Poll counter width
  localparam logic [PCW-1:0] POLL_SHORT = PCW'(`SDGC_POLL_SHORT_CYC);
  localparam logic [PCW-1:0] POLL_LONG = PCW'(POLL_LONG_CYC);
  localparam logic [7:0] INT_PULSE = 8'(`SDGC_INT_PULSE_CYC);

  // Switch closed per input type: battery type closes high
  function automatic logic [7:0] closedOf(input logic [7:0] lvl, input logic [7:0] typ);
    closedOf = ~(lvl ^ typ);
  endfunction

  // Link side
  sdgc_cmd_type cmdWord; // Last frame from the host
  logic cmdToggle; // Frame-complete event
  logic [31:0] resp_reg; // Answer for the next frame
  logic [31:0] resp_next;
  logic linkClear_reg; // Holds the link hand-off in reset

  sdgc_link_shifter u_link (
    .spiClk(spiClk),
    .spiSelN(spiSelN),
    .spiMosi(spiMosi),
    .linkClear(linkClear_reg),
    .respWord(resp_reg),
    .cmdWord(cmdWord),
    .cmdToggle(cmdToggle),
    .spiMisoOut(spiMisoOut),
    .spiMisoOeN(spiMisoOeN)
  );

  // Synchronisers for pins and the frame toggle
  logic [11:0] sync1_reg; // First stage, read only by the second
  logic [11:0] sync2_reg;
  logic [11:0] sync3_reg; // Previous value for edge detection
  // Reset to idle levels: wake pin high, supply present, inputs low, so no false edge
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sync1_reg <= 12'h00c;
      sync2_reg <= 12'h00c;
      sync3_reg <= 12'h00c;
      linkClear_reg <= 1'b1;
    end else begin
      sync1_reg <= {inputAboveThreshold, wakeInN, ioSupplyGood, batteryOvervoltage, cmdToggle};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      linkClear_reg <= 1'b0;
    end
  end

  logic frameDone; // One pulse per host frame
  logic ovNow; // Battery supply in overvoltage
  logic ioGood; // I/O supply rail present
  logic wakeFall; // Falling edge on wake pin
  logic [7:0] lvlNow; // Input comparator levels
  assign frameDone = sync2_reg[0] ^ sync3_reg[0];
  assign ovNow = sync2_reg[1];
  assign ioGood = sync2_reg[2];
  assign wakeFall = sync3_reg[3] && !sync2_reg[3];
  assign lvlNow = sync2_reg[11:4];

  // Configuration, flags and power state
  logic [23:0] cfg_reg; // Global settings word
  logic [23:0] cfg_next;
  logic ovFlag_reg; // Sticky overvoltage fault
  logic ovFlag_next;
  logic ovPrev_reg; // For entry detection
  logic intPend_reg; // Interrupt pending bit
  logic intPend_next;
  logic [7:0] closed_reg; // Debounced-free closed state
  logic [7:0] closed_next;
  sdgc_pwr_type pwr_reg;
  sdgc_pwr_type pwr_next;
  logic limit; // Overvoltage protection acting
  logic wakeOk; // Wake edge accepted
  logic swEvent; // Any switch changed
  logic [21:0] rdData; // Selected read data

  assign limit = ovNow && !cfg_reg[`SDGC_OVDIS_BIT];
  assign wakeOk = wakeFall && (cfg_reg[`SDGC_WAKECHK_BIT] || ioGood);
  assign swEvent = closed_next != closed_reg;

  // Read data by address; unmapped reads give zero
  always_comb begin
    rdData = 22'h000000;
    unique case (cmdWord.addr)
      `SDGC_ADDR_CONFIG: rdData = cfg_next[21:0];
      `SDGC_ADDR_SW_STATUS: rdData[21:`SDGC_RSP_SW_LSB] = closed_reg;
      `SDGC_ADDR_FAULT: rdData[`SDGC_FAULT_OV_BIT] = ovFlag_reg;
      default: rdData = 22'h000000;
    endcase
  end

  // Next values of the settings and status group
  always_comb begin
    cfg_next = cfg_reg;
    ovFlag_next = ovFlag_reg;
    intPend_next = intPend_reg;
    resp_next = resp_reg;
    pwr_next = pwr_reg;
    closed_next = closedOf(lvlNow, cfg_reg[7:0]);
    // Host write, masked so unused bits stay zero
    if (frameDone && cmdWord.write && cmdWord.addr == `SDGC_ADDR_CONFIG) begin
      cfg_next = cmdWord.data & `SDGC_CFG_WMASK;
    end
    // Reads clear after reporting; a new event wins
    if (frameDone && !cmdWord.write && cmdWord.addr == `SDGC_ADDR_FAULT) begin
      ovFlag_next = 1'b0;
    end
    if (frameDone && !cmdWord.write && cmdWord.addr == `SDGC_ADDR_SW_STATUS) begin
      intPend_next = 1'b0;
    end
    if (ovNow && !ovPrev_reg) begin
      ovFlag_next = 1'b1;
    end
    if (swEvent) begin
      intPend_next = 1'b1;
    end
    // Answer lands in the next frame, echoing the command header
    if (frameDone) begin
      resp_next = {cmdWord.addr, cmdWord.write, ovFlag_reg, intPend_reg, rdData};
    end
    unique case (pwr_reg)
      SDGC_NORMAL: begin
        if (lowPowerRequest && !limit) begin
          pwr_next = SDGC_LOWPWR;
        end
      end
      SDGC_LOWPWR: begin
        if (wakeOk) begin
          pwr_next = SDGC_NORMAL;
        end
      end
    endcase
  end

  // Settings and status registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cfg_reg <= `SDGC_CFG_RESET;
      ovFlag_reg <= 1'b0;
      ovPrev_reg <= 1'b0;
      intPend_reg <= 1'b0;
      closed_reg <= 8'h00;
      resp_reg <= 32'h0000_0000;
      pwr_reg <= SDGC_NORMAL;
    end else begin
      cfg_reg <= cfg_next;
      ovFlag_reg <= ovFlag_next;
      ovPrev_reg <= ovNow;
      intPend_reg <= intPend_next;
      closed_reg <= closed_next;
      resp_reg <= resp_next;
      pwr_reg <= pwr_next;
    end
  end

  // Interrupt pin and registered outputs
  logic [7:0] pulse_reg; // Low-pulse cycles left
  logic [7:0] pulse_next;
  logic intN_reg;
  logic intN_next;
  logic wet_reg;
  logic wake_reg;
  always_comb begin
    pulse_next = pulse_reg;
    if (swEvent) begin
      pulse_next = INT_PULSE;
    end else if (pulse_reg != 8'h00) begin
      pulse_next = pulse_reg - 8'h01;
    end
    // Latched style follows the pending bit; pulse style follows the timer
    if (cfg_reg[`SDGC_INTSTYLE_BIT]) begin
      intN_next = (pulse_next == 8'h00);
    end else begin
      intN_next = !intPend_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pulse_reg <= 8'h00;
      intN_reg <= 1'b1;
      wet_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      pulse_reg <= pulse_next;
      intN_reg <= intN_next;
      wet_reg <= limit;
      wake_reg <= pwr_reg == SDGC_LOWPWR && wakeOk;
    end
  end

  // Active poll timer for battery-type inputs while asleep
  logic [PCW-1:0] poll_reg;
  logic [PCW-1:0] poll_next;
  logic pollDone_reg;
  logic pollDone_next;
  logic [PCW-1:0] pollLen;
  assign pollLen = cfg_reg[`SDGC_POLL_BIT] ? POLL_SHORT : POLL_LONG;
  always_comb begin
    poll_next = 16'h0000;
    pollDone_next = 1'b0;
    if (pwr_reg == SDGC_LOWPWR && cfg_reg[7:0] != 8'h00) begin
      if (poll_reg >= pollLen - 16'h0001) begin
        pollDone_next = 1'b1;
      end else begin
        poll_next = poll_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      poll_reg <= 16'h0000;
      pollDone_reg <= 1'b0;
    end else begin
      poll_reg <= poll_next;
      pollDone_reg <= pollDone_next;
    end
  end

  assign overvoltageFlag = ovFlag_reg;
  assign wettingLimit2mA = wet_reg;
  assign lowPowerState = pwr_reg == SDGC_LOWPWR;
  assign wakeEvent = wake_reg;
  assign intOutN = intN_reg;
  assign inputTypeBattery = cfg_reg[7:0];
  assign sbPollActive = lowPowerState && cfg_reg[7:0] != 8'h00;
  assign sbPollDone = pollDone_reg;

  // Checks
  a_ov_cap_wet: assert property (@(posedge core_clk) disable iff (reset)
    ovNow && !cfg_reg[`SDGC_OVDIS_BIT] |=> wettingLimit2mA)
    else $error("wetting not capped in overvoltage");
  a_lpm_refused: assert property (@(posedge core_clk) disable iff (reset)
    pwr_reg == SDGC_NORMAL && limit |=> pwr_reg == SDGC_NORMAL)
    else $error("sleep entered under overvoltage");
  a_ovdis_normal: assert property (@(posedge core_clk) disable iff (reset)
    cfg_reg[`SDGC_OVDIS_BIT] |=> !wettingLimit2mA)
    else $error("cap active with protection disabled");
  a_ov_flag_set: assert property (@(posedge core_clk) disable iff (reset)
    ovNow && !ovPrev_reg |=> overvoltageFlag)
    else $error("overvoltage flag not set");
  a_wake_ignored: assert property (@(posedge core_clk) disable iff (reset)
    lowPowerState && !cfg_reg[`SDGC_WAKECHK_BIT] && !ioGood && wakeFall |=> lowPowerState)
    else $error("woke with supply low");
  a_wake_taken: assert property (@(posedge core_clk) disable iff (reset)
    lowPowerState && cfg_reg[`SDGC_WAKECHK_BIT] && wakeFall |=> !lowPowerState && wakeEvent)
    else $error("wake edge missed");
  a_int_latch: assert property (@(posedge core_clk) disable iff (reset)
    intPend_reg && !cfg_reg[`SDGC_INTSTYLE_BIT] && !$past(cfg_reg[`SDGC_INTSTYLE_BIT])
    && !swEvent |-> !intOutN)
    else $error("latched interrupt released");
  a_int_pulse: assert property (@(posedge core_clk) disable iff (reset)
    swEvent && cfg_reg[`SDGC_INTSTYLE_BIT] |=> !intOutN [*8])
    else $error("interrupt pulse too short");
  a_type_write: assert property (@(posedge core_clk) disable iff (reset)
    frameDone && cmdWord.write && cmdWord.addr == `SDGC_ADDR_CONFIG
    |=> inputTypeBattery == $past(cmdWord.data[7:0]))
    else $error("type bits not applied");
  a_status_read: assert property (@(posedge core_clk) disable iff (reset)
    frameDone && !cmdWord.write && cmdWord.addr == `SDGC_ADDR_SW_STATUS
    |=> resp_reg[21:14] == $past(closed_reg) && resp_reg[23] == $past(ovFlag_reg))
    else $error("status answer wrong");
  a_poll_bound: assert property (@(posedge core_clk) disable iff (reset)
    lowPowerState && cfg_reg[`SDGC_POLL_BIT] && $past(cfg_reg[`SDGC_POLL_BIT])
    |-> poll_reg < POLL_SHORT)
    else $error("short poll overran");
  a_unused_zero: assert property (@(posedge core_clk) disable iff (reset)
    (cfg_reg & ~`SDGC_CFG_WMASK) == 24'h000000)
    else $error("unused bits set");

  c_cfg_write: cover property (@(posedge core_clk)
    frameDone && cmdWord.write && cmdWord.addr == `SDGC_ADDR_CONFIG);
  c_wake: cover property (@(posedge core_clk) wakeEvent);
  c_int_pulse: cover property (@(posedge core_clk) swEvent && cfg_reg[`SDGC_INTSTYLE_BIT]);
  c_poll_done: cover property (@(posedge core_clk) sbPollDone);
endmodule // sdgc_config_bank

// [verification/sdgc_host_model.sv]
// Host side of the serial link: a behavioural link master.
// Assumes mode 0 framing and a device that shifts on the rising link edge.
`timescale 1ns/1ns
module sdgc_host_model
  import sdgc_pkg::*;
#(
  parameter int HALF_NS = 32
) (
  output logic spiClk,
  output logic spiSelN,
  output logic spiMosi,
  input wire logic spiMiso
);
  // Idle link: deselected, clock parked low
  initial begin
    spiClk = 1'b0;
    spiSelN = 1'b1;
    spiMosi = 1'b0;
  end

  // One whole 32-bit frame; gapNs sets a prompt or slow host
  task automatic xfer(input sdgc_cmd_type tx, input int gapNs, output logic [31:0] rx);
    logic [31:0] bits;
    bits = tx;
    rx = 32'h0;
    #3;
    spiSelN = 1'b0;
    for (int k = 31; k >= 0; k--) begin
      spiMosi = bits[k];
      #(HALF_NS);
      // Sample before the edge that moves the device's output on
      rx = {rx[30:0], spiMiso};
      spiClk = 1'b1;
      #(HALF_NS);
      spiClk = 1'b0;
    end
    #(HALF_NS);
    spiSelN = 1'b1;
    // Released line must not keep showing the last bit
    spiMosi = ~spiMosi;
    #(gapNs);
  endtask
endmodule // sdgc_host_model

// [verification/tb.sv]
// Self-checking bench for the global configuration bank.
// Assumes the host model above and a shortened long poll window.
`timescale 1ns/1ns
`include "sdgc_defines.svh"
`define CHK(got, exp) begin \
  nCompared++; \
  if ((got) !== (exp)) begin \
    failCount++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
module tb
  import sdgc_pkg::*;
;
  localparam int POLL_SIM = 300; // Long window cut down to keep the run short
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic spiClk, spiSelN, spiMosi, spiMisoOut, spiMisoOeN;
  logic batteryOvervoltage, ioSupplyGood, wakeInN, lowPowerRequest;
  logic [7:0] inLevel; // Comparator levels of the eight inputs
  logic overvoltageFlag, wettingLimit2mA, lowPowerState, wakeEvent, intOutN;
  logic [7:0] inputTypeBattery;
  logic sbPollActive, sbPollDone;
  logic [31:0] rsp; // Last word shifted out by the device
  int failCount = 0;
  int nCompared = 0;
  int cnt;
  // MISO wire, floating whenever the device lets go
  wire misoWire = spiMisoOeN ? 1'bz : spiMisoOut;

  // 50 MHz core clock
  always #10 core_clk = ~core_clk;

  sdgc_config_bank #(.POLL_LONG_CYC(POLL_SIM)) i_sdgc_config_bank (
    .core_clk(core_clk), .reset(reset), .spiClk(spiClk), .spiSelN(spiSelN),
    .spiMosi(spiMosi), .spiMisoOut(spiMisoOut), .spiMisoOeN(spiMisoOeN),
    .batteryOvervoltage(batteryOvervoltage), .ioSupplyGood(ioSupplyGood),
    .wakeInN(wakeInN), .inputAboveThreshold(inLevel), .lowPowerRequest(lowPowerRequest),
    .overvoltageFlag(overvoltageFlag), .wettingLimit2mA(wettingLimit2mA),
    .lowPowerState(lowPowerState), .wakeEvent(wakeEvent), .intOutN(intOutN),
    .inputTypeBattery(inputTypeBattery), .sbPollActive(sbPollActive),
    .sbPollDone(sbPollDone));

  sdgc_host_model i_sdgc_host_model (
    .spiClk(spiClk), .spiSelN(spiSelN), .spiMosi(spiMosi), .spiMiso(misoWire));

  // Land just after an edge so drives never race sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  // Configuration write; host may do this at any time
  task automatic wr(input logic [23:0] d);
    i_sdgc_host_model.xfer('{addr: `SDGC_ADDR_CONFIG, write: 1'b1, data: d}, 300, rsp);
    cyc(1);
  endtask

  // Read: command frame, then a filler frame that returns the answer
  task automatic rd(input logic [6:0] a);
    i_sdgc_host_model.xfer('{addr: a, write: 1'b0, data: 24'h0}, 300, rsp);
    i_sdgc_host_model.xfer('{addr: 7'h00, write: 1'b0, data: 24'h0}, 2000, rsp);
    `CHK(rsp[31:25], a)
    cyc(1);
  endtask

  // Reset values of outputs and of the word
  task automatic tReset();
    `CHK(inputTypeBattery, 8'hff)
    `CHK(intOutN, 1'b1)
    `CHK(spiMisoOeN, 1'b1)
    rd(`SDGC_ADDR_CONFIG);
    `CHK(rsp[21:0], 22'h0008ff)
  endtask

  // Unused bits dropped, type bits rewritten
  task automatic tMask();
    wr(24'hffffff);
    rd(`SDGC_ADDR_CONFIG);
    `CHK(rsp[21:0], 22'h003cff)
    wr(24'h0008a5);
    `CHK(inputTypeBattery, 8'ha5)
  endtask

  // Closed reads 1 for either type; last read clears pending
  task automatic tStatus();
    logic [7:0] t;
    inLevel = 8'h0f;
    for (int i = 0; i < 2; i++) begin
      t = i ? 8'ha5 : 8'h00;
      wr({16'h0008, t});
      rd(`SDGC_ADDR_SW_STATUS);
      `CHK(rsp[21:14], ~(t ^ inLevel))
    end
    cyc(5);
    `CHK(intOutN, 1'b1)
  endtask

  // Latched then pulsed interrupt pin
  task automatic tInt();
    inLevel = 8'h0e;
    cyc(20);
    `CHK(intOutN, 1'b0)
    cyc(200);
    `CHK(intOutN, 1'b0)
    rd(`SDGC_ADDR_SW_STATUS);
    cyc(3);
    `CHK(intOutN, 1'b1)
    wr(24'h000ca5);
    inLevel = 8'h0f;
    for (int i = 0; i < 40 && intOutN === 1'b1; i++) cyc(1);
    cnt = 0;
    while (intOutN === 1'b0 && cnt < 100) begin
      cnt++;
      cyc(1);
    end
    `CHK(cnt, `SDGC_INT_PULSE_CYC)
    rd(`SDGC_ADDR_SW_STATUS);
  endtask

  // Overvoltage with protection on, then disabled
  task automatic tOv();
    wr(24'h0008a5);
    batteryOvervoltage = 1'b1;
    // Sleep asked only once the overvoltage has passed the synchroniser
    cyc(3);
    lowPowerRequest = 1'b1;
    cyc(10);
    `CHK(overvoltageFlag, 1'b1)
    `CHK(wettingLimit2mA, 1'b1)
    `CHK(lowPowerState, 1'b0)
    rd(`SDGC_ADDR_CONFIG);
    `CHK(rsp[23], 1'b1)
    wr(24'h0018a5);
    cyc(10);
    `CHK(wettingLimit2mA, 1'b0)
    `CHK(lowPowerState, 1'b1)
    `CHK(overvoltageFlag, 1'b1)
    lowPowerRequest = 1'b0;
    // Fault read reports the flag, then clears it
    rd(`SDGC_ADDR_FAULT);
    `CHK(rsp[`SDGC_FAULT_OV_BIT], 1'b1)
    `CHK(overvoltageFlag, 1'b0)
  endtask

  // Gap between poll-done pulses for one setting
  task automatic pollGap(input logic [23:0] d, input int exp);
    wr(d);
    for (int i = 0; i < 6000 && sbPollDone !== 1'b1; i++) cyc(1);
    cyc(1);
    cnt = 1;
    while (sbPollDone !== 1'b1 && cnt < 6000) begin
      cnt++;
      cyc(1);
    end
    `CHK(sbPollActive, 1'b1)
    `CHK(cnt, exp)
  endtask

  // Wake ignored without supply, then taken with check set
  task automatic tWake();
    ioSupplyGood = 1'b0;
    wr(24'h0010a5);
    wakeInN = 1'b0;
    cyc(10);
    `CHK(lowPowerState, 1'b1)
    wakeInN = 1'b1;
    wr(24'h0018a5);
    wakeInN = 1'b0;
    cnt = 0;
    while (wakeEvent !== 1'b1 && cnt < 20) begin
      cnt++;
      cyc(1);
    end
    `CHK(wakeEvent, 1'b1)
    cyc(2);
    `CHK(lowPowerState, 1'b0)
    wakeInN = 1'b1;
  endtask

  // Counts and verdict, then stop
  task automatic testDone();
    $display("compared=%0d failed=%0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    batteryOvervoltage = 1'b0;
    ioSupplyGood = 1'b1;
    wakeInN = 1'b1;
    lowPowerRequest = 1'b0;
    inLevel = 8'h00;
    repeat (3) @(posedge core_clk);
    #2;
    reset = 1'b0;
    cyc(3);
    tReset();
    tMask();
    tStatus();
    tInt();
    tOv();
    pollGap(24'h0018a5, POLL_SIM);
    pollGap(24'h0038a5, `SDGC_POLL_SHORT_CYC);
    tWake();
    testDone();
  end

  // Watchdog, well beyond the expected run
  initial begin
    #(1000000);
    failCount++;
    testDone();
  end
endmodule // tb
